// [core/asp_pkg.sv]
// Shared constants for the serial configuration and result port.
package asp_pkg;

	// ********************************************************************
	// Mode byte layout
	// ********************************************************************
	localparam int MODE_W = 8;
	localparam int MODE_IM_POS = 3;
	localparam int MODE_RA_POS = 2;
	localparam int MODE_RB_POS = 1;
	localparam int MODE_DR_POS = 0;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// ********************************************************************
	// Addressing
	// ********************************************************************
	localparam logic [6:0] GLOBAL_ADDR = 7'h77;
	localparam logic [6:0] ADDR_LO_HI = 7'h14;
	localparam logic [6:0] ADDR_LO_FL = 7'h15;
	localparam logic [6:0] ADDR_FL_HI = 7'h17;
	localparam logic [6:0] ADDR_FL_FL = 7'h24;
	localparam logic [6:0] ADDR_HI_HI = 7'h26;
	localparam logic [6:0] ADDR_HI_FL = 7'h27;
	localparam logic [1:0] PIN_LOW = 2'h0;
	localparam logic [1:0] PIN_FLOAT = 2'h1;
	localparam logic [1:0] PIN_HIGH = 2'h2;

	// ********************************************************************
	// Result word and transfer sizes
	// ********************************************************************
	localparam int RES_W = 32;
	localparam int CODE_W = 31;
	localparam logic [31:0] OVER_WORD = 32'hc000_0000;
	localparam logic [31:0] UNDER_WORD = 32'h3fff_ffff;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] BYTES_PER_READ = 3'h4;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_HALF_TIME_NS = 100000;
	localparam int CONV_HALF_CYCLES =
		(CONV_HALF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_CLK_MAX_PERIOD_NS = 100000;
	localparam int EXT_CLK_TIMEOUT_CYCLES =
		(EXT_CLK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : asp_pkg

// [core/asp_conv_if.sv]
// Link between the serial control logic and the conversion engine.
`timescale 1ns/100ps
interface asp_conv_if;
	logic start;
	logic [3:0] cfg;
	logic busy;
	logic done;
	logic [31:0] result;
	modport ctrl(output start, output cfg, input busy, input done,
		input result);
	modport eng(input start, input cfg, output busy, output done,
		output result);
endinterface : asp_conv_if

// [core/asp_conv_engine.sv]
// Conversion engine model: timed conversion cycle and result formatting.
`timescale 1ns/100ps
module asp_conv_engine #(
	parameter int HALF_CYCLES = asp_pkg::CONV_HALF_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	asp_conv_if.eng cif,
	input wire logic signed [30:0] sample_in,
	input wire logic over_in,
	input wire logic under_in
);
	localparam int CW = $clog2(HALF_CYCLES + 1);

	if (HALF_CYCLES < 1) begin : g_bad_half
		$error("HALF_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {ENG_SLEEP, ENG_FIRST, ENG_SECOND} asp_eng_e;
	asp_eng_e state;
	logic [CW-1:0] cnt;
	logic fast;
	logic signed [30:0] first_code;
	logic first_over;
	logic first_under;
	logic half_end;
	logic signed [31:0] sum;

	function automatic logic [31:0] fmt(input logic ovr, input logic und,
		input logic [30:0] code);
		if (ovr) begin
			fmt = asp_pkg::OVER_WORD;
		end else if (und) begin
			fmt = asp_pkg::UNDER_WORD;
		end else begin
			fmt = {~code[30], code};
		end
	endfunction : fmt

	assign half_end = (cnt == CW'(HALF_CYCLES - 1));
	assign sum = {first_code[30], first_code} + {sample_in[30], sample_in};
	assign cif.busy = (state != ENG_SLEEP);

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state <= ENG_SLEEP;
			cnt <= '0;
			fast <= 1'b0;
		end else begin
			unique case (state)
				ENG_SLEEP: begin
					cnt <= '0;
					if (cif.start) begin
						state <= ENG_FIRST;
						// Temperature input forces normal speed.
						fast <= cif.cfg[asp_pkg::MODE_DR_POS] &
							~cif.cfg[asp_pkg::MODE_IM_POS];
					end
				end
				ENG_FIRST: begin
					cnt <= half_end ? '0 : cnt + 1'b1;
					if (half_end) begin
						state <= fast ? ENG_SLEEP : ENG_SECOND;
					end
				end
				ENG_SECOND: begin
					cnt <= half_end ? '0 : cnt + 1'b1;
					if (half_end) begin
						state <= ENG_SLEEP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			first_code <= '0;
			first_over <= 1'b0;
			first_under <= 1'b0;
			cif.result <= '0;
			cif.done <= 1'b0;
		end else begin
			cif.done <= half_end & ((state == ENG_SECOND) |
				(state == ENG_FIRST & fast));
			if (state == ENG_FIRST && half_end) begin
				first_code <= sample_in;
				first_over <= over_in;
				first_under <= under_in;
				if (fast) begin
					cif.result <= fmt(over_in, under_in, sample_in);
				end
			end else if (state == ENG_SECOND && half_end) begin
				// Two halves averaged so offset cancels; no older data used.
				cif.result <= fmt(first_over | over_in,
					first_under | under_in, sum[31:1]);
			end
		end
	end

	AST_FAST_ONE_HALF: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		(state == ENG_FIRST && half_end && fast) |=> state == ENG_SLEEP)
		else $error("double rate took more than one half");
	AST_TEMP_NORMAL: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		(state == ENG_SLEEP && cif.start && cif.cfg[asp_pkg::MODE_IM_POS])
		|=> !fast)
		else $error("temperature input ran at double rate");

endmodule : asp_conv_engine

// [core/asp_serial_port.sv]
// Two-wire slave port: addressing, mode byte, result readout, restart.
`timescale 1ns/100ps

// Overview of operation
// - Reset mode: external, 50/60Hz, normal speed.
// - Mode bit 3 selects temperature sensor input.
// - Mode bits 2,1 select line rejection.
// - Double rate bit skips calibration, doubles rate.
// - Temperature input forces normal speed.
// - Normal speed combines two internal conversions.
// - Result uses only the current cycle.
// - Busy converter refuses match with NAK.
// - Finished converter acknowledges matching address.
// - Two registers: result word, mode byte.
// - Sleep after conversion, hold result.
// - Four bytes read empties, restarts, refuses reads.
// - Result shifted MSB first on falling clock.
// - Bit 31 set for non-negative input.
// - Overrange: bits 31,30 high, next 24 low.
// - Underrange: bits 31,30 low, next 24 high.
// - Two's complement code then six sub bits.
// - Out of range clamps one LSB past scale.
// - Zero code sign may be either in double rate.
// - STOP after an accepted address, or 32 bits read, restarts conversion.
// - Global address accepted for writes.
// - Address from two pins, clock counts high.
module asp_serial_port #(
	parameter int CONV_HALF_CYCLES = asp_pkg::CONV_HALF_CYCLES,
	parameter int EXT_TIMEOUT = asp_pkg::EXT_CLK_TIMEOUT_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output wire logic sda_out,
	output wire logic sda_oe_out,
	input wire logic [1:0] addr_pin_hi_in,
	input wire logic addr_pin_lo_float_in,
	input wire logic addr_pin_lo_ext_clk_in,
	input wire logic signed [30:0] sample_in,
	input wire logic over_in,
	input wire logic under_in,
	output wire logic input_select_out,
	output wire logic reject_sel_a_out,
	output wire logic reject_sel_b_out,
	output wire logic double_rate_out,
	output wire logic conv_busy_out,
	output wire logic ext_clk_detect_out
);
	localparam int TW = $clog2(EXT_TIMEOUT + 1);

	if (EXT_TIMEOUT < 2 || CONV_HALF_CYCLES < 1) begin : g_bad_param
		$error("timing parameters too small");
	end

	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WR,
		I2C_WR_ACK, I2C_RD, I2C_RD_ACK} asp_i2c_e;

	asp_conv_if cif();

	// ********************************************************************
	// Pin synchronisers and bus events
	// ********************************************************************
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic scl_s;
	logic sda_s;
	logic ext_s;
	logic scl_prev;
	logic sda_prev;
	logic ext_prev;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pin_meta <= 6'h3f;
			pin_sync <= 6'h3f;
		end else begin
			pin_meta <= {addr_pin_lo_float_in, addr_pin_hi_in,
				addr_pin_lo_ext_clk_in, sda_in, scl_in};
			pin_sync <= pin_meta;
		end
	end

	assign scl_s = pin_sync[0];
	assign sda_s = pin_sync[1];
	assign ext_s = pin_sync[2];

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			ext_prev <= 1'b1;
		end else begin
			scl_prev <= scl_s;
			sda_prev <= sda_s;
			ext_prev <= ext_s;
		end
	end

	assign scl_rise = scl_s & ~scl_prev;
	assign scl_fall = ~scl_s & scl_prev;
	assign start_c = scl_s & scl_prev & sda_prev & ~sda_s;
	assign stop_c = scl_s & scl_prev & ~sda_prev & sda_s;

	// ********************************************************************
	// Address pins and external clock detection
	// ********************************************************************
	logic [TW-1:0] ext_idle;
	logic ext_det;
	logic [6:0] my_addr;

	// Detection drops only after a full slowest period with no edge.
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ext_idle <= '0;
			ext_det <= 1'b0;
		end else if (ext_s != ext_prev) begin
			ext_idle <= '0;
			ext_det <= 1'b1;
		end else if (ext_idle == TW'(EXT_TIMEOUT - 1)) begin
			ext_det <= 1'b0;
		end else begin
			ext_idle <= ext_idle + 1'b1;
		end
	end

	function automatic logic [6:0] addr_of(input logic [1:0] hi,
		input logic lo_high);
		unique case (hi)
			asp_pkg::PIN_LOW: addr_of = lo_high ? asp_pkg::ADDR_LO_HI :
				asp_pkg::ADDR_LO_FL;
			asp_pkg::PIN_HIGH: addr_of = lo_high ? asp_pkg::ADDR_HI_HI :
				asp_pkg::ADDR_HI_FL;
			default: addr_of = lo_high ? asp_pkg::ADDR_FL_HI :
				asp_pkg::ADDR_FL_FL;
		endcase
	endfunction : addr_of

	assign my_addr = addr_of(pin_sync[4:3], ext_det | ~pin_sync[5]);
	assign ext_clk_detect_out = ext_det;

	// ********************************************************************
	// Serial state machine
	// ********************************************************************
	asp_i2c_e state;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic rw;
	logic [31:0] tx_word;
	logic sda_oe;
	logic master_ack;
	logic addr_done;
	logic addr_hit;
	logic accept;
	logic mode_wr;
	logic read_done;

	assign addr_done = (state == I2C_ADDR) && scl_fall &&
		(bit_cnt == asp_pkg::BITS_PER_BYTE);
	assign addr_hit = (shreg[7:1] == my_addr) ||
		(shreg[7:1] == asp_pkg::GLOBAL_ADDR && !shreg[0]);
	logic result_full;
	assign accept = addr_hit && !cif.busy &&
		(!shreg[0] || result_full);
	assign mode_wr = (state == I2C_WR) && scl_fall &&
		(bit_cnt == asp_pkg::BITS_PER_BYTE) && (byte_cnt == 3'h0);
	assign read_done = (state == I2C_RD_ACK) && scl_fall &&
		(byte_cnt == asp_pkg::BYTES_PER_READ);

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state <= I2C_IDLE;
			shreg <= 8'h00;
			bit_cnt <= 4'h0;
			byte_cnt <= 3'h0;
			rw <= 1'b0;
			tx_word <= 32'h0000_0000;
			sda_oe <= 1'b0;
			master_ack <= 1'b0;
		end else if (start_c) begin
			state <= I2C_ADDR;
			bit_cnt <= 4'h0;
			byte_cnt <= 3'h0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			state <= I2C_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				I2C_IDLE: sda_oe <= 1'b0;
				I2C_ADDR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 1'b1;
					end
					if (addr_done) begin
						rw <= shreg[0];
						tx_word <= cif.result;
						sda_oe <= accept;
						state <= accept ? I2C_ADDR_ACK : I2C_IDLE;
					end
				end
				I2C_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						state <= rw ? I2C_RD : I2C_WR;
						sda_oe <= rw & ~tx_word[31];
						if (rw) begin
							tx_word <= {tx_word[30:0], 1'b0};
						end
					end
				end
				I2C_WR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 1'b1;
					end
					if (scl_fall && bit_cnt == asp_pkg::BITS_PER_BYTE) begin
						// Only byte 1 of a frame (and 9, 17... as the count wraps) is taken as mode; others get NAK.
						sda_oe <= (byte_cnt == 3'h0);
						byte_cnt <= byte_cnt + 1'b1;
						state <= I2C_WR_ACK;
					end
				end
				I2C_WR_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						bit_cnt <= 4'h0;
						state <= I2C_WR;
					end
				end
				I2C_RD: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h7) begin
							sda_oe <= 1'b0;
							bit_cnt <= 4'h0;
							byte_cnt <= byte_cnt + 1'b1;
							state <= I2C_RD_ACK;
						end else begin
							sda_oe <= ~tx_word[31];
							tx_word <= {tx_word[30:0], 1'b0};
							bit_cnt <= bit_cnt + 1'b1;
						end
					end
				end
				I2C_RD_ACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_s;
					end
					if (read_done || (scl_fall && !master_ack)) begin
						state <= I2C_IDLE;
					end else if (scl_fall) begin
						sda_oe <= ~tx_word[31];
						tx_word <= {tx_word[30:0], 1'b0};
						state <= I2C_RD;
					end
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = sda_oe;

	// ********************************************************************
	// Mode register and conversion sequencing
	// ********************************************************************
	logic [7:0] mode_reg;
	logic armed;
	logic por_start;
	logic conv_start;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			mode_reg <= asp_pkg::MODE_RESET;
		end else if (mode_wr) begin
			mode_reg <= shreg;
		end
	end

	assign input_select_out = mode_reg[asp_pkg::MODE_IM_POS];
	assign reject_sel_a_out = mode_reg[asp_pkg::MODE_RA_POS];
	assign reject_sel_b_out = mode_reg[asp_pkg::MODE_RB_POS];
	assign double_rate_out = mode_reg[asp_pkg::MODE_DR_POS];
	assign cif.cfg = mode_reg[3:0];
	assign cif.start = conv_start;
	assign conv_busy_out = cif.busy;

	// A new conversion always discards the held result.
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			por_start <= 1'b1;
			armed <= 1'b0;
			conv_start <= 1'b0;
			result_full <= 1'b0;
		end else begin
			por_start <= 1'b0;
			conv_start <= por_start | read_done | (stop_c & armed);
			if (addr_done && accept) begin
				armed <= 1'b1;
			end else if (read_done || stop_c) begin
				armed <= 1'b0;
			end
			if (cif.done) begin
				result_full <= 1'b1;
			end else if (read_done || conv_start) begin
				result_full <= 1'b0;
			end
		end
	end

	asp_conv_engine #(.HALF_CYCLES(CONV_HALF_CYCLES)) u_engine (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.cif(cif),
		.sample_in(sample_in),
		.over_in(over_in),
		.under_in(under_in)
	);

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	AST_NAK_WHEN_BUSY: assert property (
		(addr_done && cif.busy) |=> !sda_oe && state == I2C_IDLE)
		else $error("busy converter did not refuse");
	AST_ACK_WHEN_DONE: assert property (
		(addr_done && addr_hit && !cif.busy && !shreg[0])
		|=> sda_oe && state == I2C_ADDR_ACK)
		else $error("idle converter did not acknowledge write");
	AST_MODE_HOLDS: assert property (
		!mode_wr |=> $stable(mode_reg))
		else $error("mode changed without a write");
	AST_READ_RESTARTS: assert property (
		read_done |=> conv_start ##1 cif.busy && !result_full)
		else $error("full read did not restart conversion");
	AST_EMPTY_NAK: assert property (
		(addr_done && shreg[0] && !result_full) |=> !sda_oe)
		else $error("read accepted with empty result");
	AST_STOP_RESTARTS: assert property (
		(stop_c && armed) |=> conv_start)
		else $error("stop in output phase did not restart");
	AST_MSB_FIRST: assert property (
		(state == I2C_ADDR_ACK && scl_fall && rw)
		|=> sda_oe == !cif.result[31])
		else $error("first result bit wrong");
	AST_SLEEP_HOLDS: assert property (
		(!cif.busy && !conv_start) |=> $stable(cif.result))
		else $error("held result changed while asleep");
	AST_DRIVE_ON_FALL: assert property (
		$rose(sda_oe) |-> $past(scl_fall))
		else $error("data line driven away from a falling clock");

	COV_READ_ALL: cover property (read_done);
	COV_MODE_WRITE: cover property (mode_wr);
	COV_BUSY_NAK: cover property (addr_done && addr_hit && cif.busy);

endmodule : asp_serial_port

// [dv/asp_i2c_master.sv]
// Behavioural two-wire bus master that drives the serial port's far side.
`timescale 1ns/100ps
module asp_i2c_master (
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	// ******************
	// Bus idle and bit slot
	// ******************
	// The clock stands high between frames; the bench's pull-up makes a
	// released data line read high, never the last driven value.
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// Data moves 50 ns after the falling clock and is sampled midway through the
	// high phase, since the device answers only a few core clocks after
	// it sees the fall through its synchroniser.
	task automatic put_bit(input logic b, output logic s);
		#50 sda_low_out = ~b;
		#150 scl_out = 1'b1;
		#100 s = sda_in;
		#100 scl_out = 1'b0;
	endtask : put_bit

	task automatic start(input logic again);
		if (again) begin
			#50 sda_low_out = 1'b0;
			#150 scl_out = 1'b1;
		end
		#100 sda_low_out = 1'b1;
		#100 scl_out = 1'b0;
	endtask : start

	task automatic stop();
		#50 sda_low_out = 1'b1;
		#150 scl_out = 1'b1;
		#100 sda_low_out = 1'b0;
		#200;
	endtask : stop

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], s);
		end
		put_bit(1'b1, ack);
	endtask : wr_byte

	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(last, s);
	endtask : rd_byte
endmodule : asp_i2c_master

// [dv/tb_asp_serial_port.sv]
// Self-checking bench for the two-wire configuration and result port.
`timescale 1ns/100ps
module tb_asp_serial_port;
	localparam int HALF = 100;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [1:0] pin_a = 2'h0;
	logic pin_b_float = 1'b0;
	logic pin_b_lvl = 1'b1;
	logic ext_run = 1'b0;
	logic signed [30:0] sample = 31'h0000_1234;
	logic over = 1'b0;
	logic under = 1'b0;
	logic scl, m_low, sda_out, sda_oe, is_o, ra_o, rb_o, dr_o, busy, ext_det;
	wire sda_line = !m_low && !(sda_oe && !sda_out);
	logic [3:0] mode_o;
	assign mode_o = {is_o, ra_o, rb_o, dr_o};
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 32'h8ad123c9;
	logic signed [30:0] ctab [4] = '{31'h0, 31'h7fff_ffff, 31'h3fff_ffff,
		31'h4000_0000};
	logic [6:0] atab [6] = '{asp_pkg::ADDR_LO_HI, asp_pkg::ADDR_LO_FL,
		asp_pkg::ADDR_FL_HI, asp_pkg::ADDR_FL_FL, asp_pkg::ADDR_HI_HI,
		asp_pkg::ADDR_HI_FL};
	// Reserved rejection pair 11 never appears among these bytes.
	logic [7:0] mtab [10] = '{8'h00, 8'h02, 8'h04, 8'h01, 8'h03, 8'h09,
		8'h08, 8'h0b, 8'h0d, 8'h05};

	asp_serial_port #(.CONV_HALF_CYCLES(HALF), .EXT_TIMEOUT(50))
		asp_serial_port_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_out(sda_oe), .addr_pin_hi_in(pin_a),
		.addr_pin_lo_float_in(pin_b_float),
		.addr_pin_lo_ext_clk_in(pin_b_lvl), .sample_in(sample),
		.over_in(over), .under_in(under), .input_select_out(is_o),
		.reject_sel_a_out(ra_o), .reject_sel_b_out(rb_o),
		.double_rate_out(dr_o), .conv_busy_out(busy),
		.ext_clk_detect_out(ext_det));
	asp_i2c_master asp_i2c_master_i (.scl_out(scl), .sda_low_out(m_low),
		.sda_in(sda_line));

	always #25 core_clk_in = ~core_clk_in;

	always begin
		repeat (5) @(negedge core_clk_in);
		if (ext_run)
			pin_b_lvl = ~pin_b_lvl;
	end

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			conclude();
		end
	end

	// ******************
	// Helpers
	// ******************
	function automatic logic [31:0] word_of(input logic signed [30:0] s,
		input logic ov, input logic un);
		if (ov)
			return asp_pkg::OVER_WORD;
		if (un)
			return asp_pkg::UNDER_WORD;
		return {~s[30], s};
	endfunction : word_of

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic wait_idle();
		for (int i = 0; i < 4 * HALF && busy !== 1'b0; i++)
			@(negedge core_clk_in);
	endtask : wait_idle

	task automatic read_word(input logic [6:0] a, input int nb,
		output logic ack, output logic [31:0] w);
		logic [7:0] b;
		w = 32'h0;
		asp_i2c_master_i.start(1'b0);
		asp_i2c_master_i.wr_byte({a, 1'b1}, ack);
		for (int i = 0; i < nb && ack === 1'b0; i++) begin
			asp_i2c_master_i.rd_byte(i == nb - 1, b);
			w = {w[23:0], b};
		end
	endtask : read_word

	task automatic rd_check(input logic [6:0] a, input logic [31:0] e);
		logic ack;
		logic [31:0] w;
		read_word(a, 4, ack, w);
		chk("read_ack", 32'h0, {31'h0, ack});
		chk("result_word", e, w);
		repeat (6) @(negedge core_clk_in);
		chk("restart_busy", 32'h1, {31'h0, busy});
		asp_i2c_master_i.start(1'b1);
		asp_i2c_master_i.wr_byte({a, 1'b1}, ack);
		chk("reread_nak", 32'h1, {31'h0, ack});
		asp_i2c_master_i.stop();
	endtask : rd_check

	// A short stop tail means up to a few busy cycles pass uncounted.
	task automatic wr_mode(input logic [6:0] a, input logic [7:0] m);
		logic ack;
		int n;
		logic [31:0] e;
		wait_idle();
		asp_i2c_master_i.start(1'b0);
		asp_i2c_master_i.wr_byte({a, 1'b0}, ack);
		chk("addr_ack", 32'h0, {31'h0, ack});
		asp_i2c_master_i.wr_byte(m, ack);
		chk("mode_ack", 32'h0, {31'h0, ack});
		asp_i2c_master_i.stop();
		chk("mode_bits", 32'(m[3:0]), 32'(mode_o));
		n = 0;
		for (int i = 0; i < 40 && busy !== 1'b1; i++)
			@(negedge core_clk_in);
		while (busy === 1'b1 && n < 1000) begin
			@(negedge core_clk_in);
			n++;
		end
		e = (m[0] && !m[3]) ? HALF : 2 * HALF;
		chk("conv_len", e, (n >= e - 8 && n <= e + 2) ? e : 32'(n));
	endtask : wr_mode

	// ******************
	// Main sequence
	// ******************
	initial begin
		logic ack;
		logic [31:0] w;
		logic [31:0] e;
		int k;
		repeat (4) @(negedge core_clk_in);
		reset_in = 1'b0;
		chk("mode_reset", 32'h0, 32'(mode_o));
		chk("oe_reset", 32'h0, {31'h0, sda_oe});
		chk("sda_level", 32'h0, {31'h0, sda_out});
		repeat (3) @(negedge core_clk_in);
		chk("busy_start", 32'h1, {31'h0, busy});
		read_word(asp_pkg::ADDR_LO_HI, 1, ack, w);
		chk("busy_nak", 32'h1, {31'h0, ack});
		asp_i2c_master_i.stop();
		e = word_of(sample, over, under);
		// Each pass sets up the next conversion's input, then reads the
		// pending result at the address that the pins select.
		for (int i = 0; i < 12; i++) begin
			k = i % 6;
			wait_idle();
			pin_a = 2'(k / 2);
			pin_b_float = (k % 2 == 1);
			over = (i == 4);
			under = (i == 5);
			sample = (i < 4) ? ctab[i] : 31'($random(seed));
			repeat (4) @(negedge core_clk_in);
			rd_check(atab[k], e);
			e = word_of(sample, over, under);
		end
		wait_idle();
		pin_a = asp_pkg::PIN_LOW;
		ext_run = 1'b1;
		repeat (30) @(negedge core_clk_in);
		chk("ext_detect", 32'h1, {31'h0, ext_det});
		rd_check(asp_pkg::ADDR_LO_HI, e);
		ext_run = 1'b0;
		pin_b_float = 1'b0;
		repeat (120) @(negedge core_clk_in);
		chk("ext_gone", 32'h0, {31'h0, ext_det});
		wait_idle();
		read_word(7'h55, 1, ack, w);
		chk("foreign_nak", 32'h1, {31'h0, ack});
		asp_i2c_master_i.stop();
		// The last mode is double rate, so a zero code shows the sign choice.
		sample = 31'h0;
		e = word_of(sample, over, under);
		for (int i = 0; i < 10; i++)
			wr_mode(i % 2 ? asp_pkg::GLOBAL_ADDR : atab[0], mtab[i]);
		wait_idle();
		read_word(asp_pkg::ADDR_LO_HI, 1, ack, w);
		chk("read_ack_2x", 32'h0, {31'h0, ack});
		chk("first_byte", {24'h0, e[31:24]}, {24'h0, w[7:0]});
		asp_i2c_master_i.stop();
		repeat (6) @(negedge core_clk_in);
		chk("stop_restart", 32'h1, {31'h0, busy});
		conclude();
	end
endmodule : tb_asp_serial_port
